// File: hdl/request_checker_defines.vh
`ifndef REQUEST_CHECKER_DEFINES_VH
`define REQUEST_CHECKER_DEFINES_VH

// system error codes returned on a refused request
`define SYSERR_PARITY        8'h01
`define SYSERR_OVERRUN       8'h02
`define SYSERR_CHECKSUM      8'h03
`define SYSERR_ADDR_SPAN     8'h04
`define SYSERR_ILLEGAL_ADDR  8'h05
`define SYSERR_UNKNOWN_NODE  8'h06
`define SYSERR_BAD_INDICATOR 8'h11
`define SYSERR_BAD_COMMAND   8'h12
`define SYSERR_BAD_LENGTH    8'h15
`define SYSERR_NONE          8'h00

// request codes and their exact lengths in characters, checksum included
`define REQ_READ             8'h01
`define REQ_WRITE_NODE       8'h02
`define REQ_INDICATOR        8'h03
`define REQ_STATUS           8'h04
`define LEN_READ             4'h5
`define LEN_WRITE_NODE       4'h6
`define LEN_INDICATOR        4'h3
`define LEN_STATUS           4'h2

// character positions inside a request
`define POS_CODE             4'h0
`define POS_ADDR_HI          4'h1
`define POS_ADDR_LO          4'h2
`define POS_COUNT            4'h3
`define POS_NODE             4'h4
`define POS_SELECT           4'h1
`define POS_MAX              4'hf

// diagnostic fault vector: bit index and two-digit bcd code
`define DIAG_COUNT           12
`define DIAG_FATAL_SCRATCH   4
`define DIAG_FATAL_MEMCFG    7
`define DIAG_CODE_TABLE      96'h14_13_12_11_10_07_06_05_04_03_02_01

// receiver states, one-hot
`define ST_IDLE              2'b01
`define ST_RECV              2'b10

`endif

// File: hdl/diag_fault_latch.v
`timescale 1ns/1ns
`default_nettype none
`include "request_checker_defines.vh"

module diag_fault_latch #(
	parameter N = `DIAG_COUNT
) (
	input  wire       core_clk_in,
	input  wire       reset_in,
	input  wire [N-1:0] fault_in,
	input  wire       supervisory_in,
	input  wire       ack_in,
	output wire       report_valid_out,
	output reg  [7:0] code_ff,
	output reg        fatal_ff
);
	localparam [8*N-1:0] CODES = `DIAG_CODE_TABLE;

	reg  [N-1:0] pending_ff;
	reg  [N-1:0] shown_ff;
	reg          any_ff;
	reg  [N-1:0] lowest;
	integer      k;
	integer      j;

	// lowest pending fault is reported first
	always @* begin
		lowest = {N{1'b0}};
		for (k = N - 1; k >= 0; k = k - 1) begin
			if (pending_ff[k]) begin
				lowest = {N{1'b0}};
				lowest[k] = 1'b1;
			end
		end
	end

	genvar i;
	generate
		for (i = 0; i < N; i = i + 1) begin : g_fault
			// a fault arriving with the ack stays pending
			always @(posedge core_clk_in) begin
				if (reset_in) begin
					pending_ff[i] <= 1'b0;
				end else if (fault_in[i]) begin
					pending_ff[i] <= 1'b1;
				end else if (ack_in && report_valid_out && shown_ff[i]) begin
					pending_ff[i] <= 1'b0;
				end
			end
		end
	endgenerate

	always @(posedge core_clk_in) begin
		if (reset_in) begin
			shown_ff <= {N{1'b0}};
			any_ff   <= 1'b0;
			code_ff  <= 8'h00;
			fatal_ff <= 1'b0;
		end else begin
			shown_ff <= lowest;
			any_ff   <= |lowest;
			code_ff  <= 8'h00;
			// own loop index, so the comb search and this process share no variable
			for (j = 0; j < N; j = j + 1) begin
				if (lowest[j]) begin
					code_ff <= CODES[8*j +: 8]; // R11 R13 R14
				end
			end
			// fatal faults hold until reset
			if (fault_in[`DIAG_FATAL_SCRATCH] || fault_in[`DIAG_FATAL_MEMCFG]) begin
				fatal_ff <= 1'b1; // R12
			end
		end
	end

	// only offered while the panel sits in supervisory status
	assign report_valid_out = any_ff && supervisory_in && (shown_ff == lowest); // R10
endmodule
`default_nettype wire

// File: hdl/plc_request_error_reporter.v
`timescale 1ns/1ns
`default_nettype none
`include "request_checker_defines.vh"

// Notes on behaviour
// R1: link faults answer code 1 parity, 2 overrun, 3 checksum.
// R2: content faults answer code 4 span, 5 illegal address, 6 unknown node.
// R3: computed checksum differing from sent checksum refuses with checksum fault.
// R4: modification crossing the valid address boundary refuses with span fault.
// R5: address wholly outside memory refuses with illegal address fault.
// R6: unrecognised node type refuses with unknown node fault.
// R7: unknown request code refuses with bad command fault.
// R8: wrong character count for the request type refuses with bad length.
// R9: malformed indicator status request refuses with bad indicator fault.
// R10: in supervisory status internal faults are reported as two-digit codes.
// R11: codes 04 port error, 06 coil ram sum, 07 processor diagnostic.
// R12: codes 05 and 10 are fatal and put the run indicator out.
// R13: code 11 clock not running, code 12 watchdog expired.
// R14: code 13 illegal column, code 14 missing end-of-logic node.
// R15: panel waits while another party occupies the link.
// R16: panel flags unrecognisable responses as a system error.
// R17: panel refuses stop-only functions while the controller runs.
// R18: panel shows an invalid marker for register values above 999.
// R19: panel missing end-of-logic mark flags database invalid, asks initialisation.
// R20: receive overrun answers overrun fault and drops run indication.
// R21: refused requests change nothing; only the error response goes out.
module plc_request_error_reporter #(
	parameter MEM_WORDS       = 17'h01000,
	parameter NODE_TYPES      = 8'h10,
	parameter INDICATOR_GROUPS = 8'h08
) (
	input  wire        core_clk_in,
	input  wire        reset_in,
	input  wire        rx_valid_in,
	input  wire [7:0]  rx_data_in,
	input  wire        rx_parity_err_in,
	input  wire        rx_last_in,
	input  wire        proc_stall_in,
	input  wire        run_enable_in,
	input  wire [11:0] diag_fault_in,
	input  wire        supervisory_in,
	input  wire        diag_ack_in,
	output wire        link_occupied_out,
	output reg         resp_valid_ff,
	output reg         resp_error_ff,
	output reg  [7:0]  resp_code_ff,
	output reg         exec_valid_ff,
	output reg  [7:0]  exec_cmd_ff,
	output reg  [15:0] exec_addr_ff,
	output reg  [7:0]  exec_count_ff,
	output reg  [7:0]  exec_node_ff,
	output wire        diag_valid_out,
	output wire [7:0]  diag_code_out,
	output wire        run_out
);
	reg        hold_full_ff;
	reg  [7:0] hold_data_ff;
	reg        hold_last_ff;
	reg        hold_perr_ff;
	reg  [1:0] st_ff;
	reg  [3:0] pos_ff;
	reg  [7:0] sum_ff;
	reg        perr_ff;
	reg        ovr_ff;
	reg        run_lost_ff;
	reg  [7:0] cmd_ff;
	reg  [7:0] ahi_ff;
	reg  [7:0] alo_ff;
	reg  [7:0] cnt_ff;
	reg  [7:0] node_ff;

	wire       consume = hold_full_ff && !proc_stall_in;
	// one holding register; a character landing on an unread one is lost
	wire       overrun = rx_valid_in && hold_full_ff && !consume;
	wire       fatal;

	wire [16:0] addr  = {1'b0, ahi_ff, alo_ff};
	wire [16:0] a_end = addr + {9'h000, cnt_ff};
	wire [3:0]  len   = pos_ff + 4'h1;
	reg  [3:0]  need_len;
	reg  [7:0]  verdict;

	always @* begin
		case (cmd_ff)
			`REQ_READ:       need_len = `LEN_READ;
			`REQ_WRITE_NODE: need_len = `LEN_WRITE_NODE;
			`REQ_INDICATOR:  need_len = `LEN_INDICATOR;
			`REQ_STATUS:     need_len = `LEN_STATUS;
			default:         need_len = 4'h0;
		endcase
	end

	// link faults first, then shape of the request, then its content
	always @* begin
		verdict = `SYSERR_NONE;
		if (perr_ff || hold_perr_ff) begin
			verdict = `SYSERR_PARITY; // R1
		end else if (ovr_ff) begin
			verdict = `SYSERR_OVERRUN; // R1 R20
		end else if (sum_ff != hold_data_ff) begin
			verdict = `SYSERR_CHECKSUM; // R3
		end else if (need_len == 4'h0) begin
			verdict = `SYSERR_BAD_COMMAND; // R7
		end else if (len != need_len) begin
			verdict = `SYSERR_BAD_LENGTH; // R8
		end else if (cmd_ff == `REQ_INDICATOR) begin
			if (ahi_ff >= INDICATOR_GROUPS) begin
				verdict = `SYSERR_BAD_INDICATOR; // R9
			end
		end else if (cmd_ff == `REQ_READ || cmd_ff == `REQ_WRITE_NODE) begin
			if (addr >= MEM_WORDS) begin
				verdict = `SYSERR_ILLEGAL_ADDR; // R5
			end else if (a_end > MEM_WORDS) begin
				verdict = `SYSERR_ADDR_SPAN; // R4
			end else if (cmd_ff == `REQ_WRITE_NODE && node_ff >= NODE_TYPES) begin
				verdict = `SYSERR_UNKNOWN_NODE; // R6
			end
		end
	end

	always @(posedge core_clk_in) begin
		if (reset_in) begin
			hold_full_ff <= 1'b0;
			hold_data_ff <= 8'h00;
			hold_last_ff <= 1'b0;
			hold_perr_ff <= 1'b0;
		end else if (rx_valid_in && (!hold_full_ff || consume)) begin
			hold_full_ff <= 1'b1;
			hold_data_ff <= rx_data_in;
			hold_last_ff <= rx_last_in;
			hold_perr_ff <= rx_parity_err_in;
		end else if (consume) begin
			hold_full_ff <= 1'b0;
		end
	end

	always @(posedge core_clk_in) begin
		if (reset_in) begin
			st_ff       <= `ST_IDLE;
			pos_ff      <= `POS_CODE;
			sum_ff      <= 8'h00;
			perr_ff     <= 1'b0;
			ovr_ff      <= 1'b0;
			run_lost_ff <= 1'b0;
			cmd_ff      <= 8'h00;
			ahi_ff      <= 8'h00;
			alo_ff      <= 8'h00;
			cnt_ff      <= 8'h00;
			node_ff     <= 8'h00;
		end else begin
			if (overrun) begin
				ovr_ff      <= 1'b1;
				run_lost_ff <= 1'b1; // R20
			end
			if (consume) begin
				if (hold_last_ff) begin
					st_ff   <= `ST_IDLE;
					pos_ff  <= `POS_CODE;
					sum_ff  <= 8'h00;
					perr_ff <= 1'b0;
					ovr_ff  <= overrun;
				end else begin
					st_ff   <= `ST_RECV;
					// position saturates so long requests still read as bad length
					pos_ff  <= (pos_ff == `POS_MAX) ? pos_ff : pos_ff + 4'h1;
					sum_ff  <= sum_ff + hold_data_ff;
					perr_ff <= perr_ff | hold_perr_ff;
					case (pos_ff)
						`POS_CODE:    cmd_ff  <= hold_data_ff;
						`POS_ADDR_HI: ahi_ff  <= hold_data_ff;
						`POS_ADDR_LO: alo_ff  <= hold_data_ff;
						`POS_COUNT:   cnt_ff  <= hold_data_ff;
						`POS_NODE:    node_ff <= hold_data_ff;
						default:      node_ff <= node_ff;
					endcase
				end
			end
		end
	end

	// the last character carries the checksum and triggers the verdict
	always @(posedge core_clk_in) begin
		if (reset_in) begin
			resp_valid_ff <= 1'b0;
			resp_error_ff <= 1'b0;
			resp_code_ff  <= `SYSERR_NONE;
			exec_valid_ff <= 1'b0;
			exec_cmd_ff   <= 8'h00;
			exec_addr_ff  <= 16'h0000;
			exec_count_ff <= 8'h00;
			exec_node_ff  <= 8'h00;
		end else begin
			resp_valid_ff <= consume && hold_last_ff;
			exec_valid_ff <= consume && hold_last_ff && (verdict == `SYSERR_NONE); // R21
			if (consume && hold_last_ff) begin
				resp_error_ff <= (verdict != `SYSERR_NONE);
				resp_code_ff  <= verdict; // R1 R2
				if (verdict == `SYSERR_NONE) begin
					exec_cmd_ff   <= cmd_ff; // R21
					exec_addr_ff  <= {ahi_ff, alo_ff};
					exec_count_ff <= cnt_ff;
					exec_node_ff  <= node_ff;
				end
			end
		end
	end

	diag_fault_latch #(
		.N(`DIAG_COUNT)
	) u_diag (
		.core_clk_in      (core_clk_in),
		.reset_in         (reset_in),
		.fault_in         (diag_fault_in),
		.supervisory_in   (supervisory_in),
		.ack_in           (diag_ack_in),
		.report_valid_out (diag_valid_out),
		.code_ff          (diag_code_out),
		.fatal_ff         (fatal)
	);

	assign link_occupied_out = (st_ff == `ST_RECV) || hold_full_ff; // R15
	assign run_out           = run_enable_in && !fatal && !run_lost_ff; // R12 R20
endmodule
`default_nettype wire

// File: tb/reporter_sva.sv
`timescale 1ns/1ns
`default_nettype none
module reporter_sva (
	input wire        core_clk_in,
	input wire        reset_in,
	input wire        rx_valid_in,
	input wire        rx_last_in,
	input wire        rx_parity_err_in,
	input wire        proc_stall_in,
	input wire        run_enable_in,
	input wire [11:0] diag_fault_in,
	input wire        supervisory_in,
	input wire        diag_ack_in,
	input wire        resp_valid_ff,
	input wire        resp_error_ff,
	input wire [7:0]  resp_code_ff,
	input wire        exec_valid_ff,
	input wire        diag_valid_out,
	input wire [7:0]  diag_code_out,
	input wire        run_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (reset_in);
	property p_quiet; resp_valid_ff && resp_error_ff |-> !exec_valid_ff; endproperty
	a_quiet: assert property (p_quiet) else $error("exec on refusal");
	property p_exec; exec_valid_ff |-> resp_valid_ff && resp_code_ff == 8'h00; endproperty
	a_exec: assert property (p_exec) else $error("exec without accept");
	// stall low on both edges so the last char is surely consumed
	property p_par;
		rx_valid_in && rx_last_in && rx_parity_err_in && !proc_stall_in ##1 !proc_stall_in
		|=> resp_valid_ff && resp_code_ff == 8'h01;
	endproperty
	a_par: assert property (p_par) else $error("parity code missing");
	property p_fatal; diag_fault_in[4] || diag_fault_in[7] |=> !run_out; endproperty
	a_fatal: assert property (p_fatal) else $error("run kept on fatal");
	property p_stick; !run_out && run_enable_in |=> !run_out; endproperty
	a_stick: assert property (p_stick) else $error("run came back");
	property p_gate; run_out |-> run_enable_in; endproperty
	a_gate: assert property (p_gate) else $error("run without enable");
	property p_sup; diag_valid_out |-> supervisory_in; endproperty
	a_sup: assert property (p_sup) else $error("diag outside supervisory");
	property p_hold;
		diag_valid_out && !diag_ack_in && diag_fault_in == 12'h000
		|=> !supervisory_in || diag_valid_out && $stable(diag_code_out);
	endproperty
	a_hold: assert property (p_hold) else $error("diag code dropped");
	c_refuse: cover property (resp_valid_ff && resp_error_ff);
	c_exec: cover property (exec_valid_ff);
	c_ack: cover property (diag_valid_out && diag_ack_in);
endmodule
bind plc_request_error_reporter reporter_sva u_sva (.*);
`default_nettype wire

// File: tb/panel_model.sv
`timescale 1ns/1ns
`default_nettype none
module panel_model (
	input  wire             core_clk_in,
	input  wire             link_occupied_in,
	output var logic        rx_valid_out,
	output var logic [7:0]  rx_data_out,
	output var logic        rx_last_out,
	output var logic        rx_perr_out
);
	initial {rx_valid_out, rx_data_out, rx_last_out, rx_perr_out} = 11'h000;
	task automatic send(input [63:0] b, input integer n, input bit bad, input integer par);
		integer i;
		logic [7:0] sum;
		begin
			sum = 8'h00;
			for (i = 0; i < 40 && link_occupied_in; i++) @(posedge core_clk_in) #1;
			if (link_occupied_in) begin
				plc_request_error_reporter_tb.miscompares++;
				$display("mismatch t=%0t link never freed", $time);
			end
			for (i = 0; i <= n; i++) begin
				@(posedge core_clk_in);
				rx_valid_out <= 1'b1;
				rx_data_out <= (i == n) ? sum + bad : b[8*i +: 8];
				rx_last_out <= (i == n);
				rx_perr_out <= (i == par);
				sum = sum + b[8*i +: 8];
			end
			@(posedge core_clk_in);
			// idle line shows the inverse so a stale char never looks new
			{rx_valid_out, rx_last_out, rx_perr_out} <= 3'b000;
			rx_data_out <= ~rx_data_out;
		end
	endtask
endmodule
`default_nettype wire

// File: tb/plc_request_error_reporter_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, w) begin tests_run++; if ((g) !== (w)) begin miscompares++; \
	$display("mismatch t=%0t got %h want %h", $time, g, w); end end
module plc_request_error_reporter_tb;
	reg         core_clk_in = 1'b0;
	reg         reset_in = 1'b1;
	reg         proc_stall_in = 1'b0;
	reg         run_enable_in = 1'b1;
	reg         supervisory_in = 1'b0;
	reg         diag_ack_in = 1'b0;
	reg  [11:0] diag_fault_in = 12'h000;
	wire        rx_valid_in, rx_parity_err_in, rx_last_in, link_occupied_out;
	wire        resp_valid_ff, resp_error_ff, exec_valid_ff, diag_valid_out, run_out;
	wire [7:0]  rx_data_in, resp_code_ff, exec_cmd_ff, exec_count_ff, exec_node_ff;
	wire [7:0]  diag_code_out;
	wire [15:0] exec_addr_ff;
	integer     miscompares = 0;
	integer     tests_run = 0;
	always #50 core_clk_in = ~core_clk_in;
	panel_model pm (.core_clk_in, .link_occupied_in(link_occupied_out), .rx_valid_out(rx_valid_in),
		.rx_data_out(rx_data_in), .rx_last_out(rx_last_in), .rx_perr_out(rx_parity_err_in));
	plc_request_error_reporter DUT (.*);
	task complete_run;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task bound(input bit bad);
		if (bad) begin
			miscompares++;
			complete_run;
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge core_clk_in) #1;
	endtask
	task do_reset;
		reset_in <= 1'b1;
		tick(6);
		reset_in <= 1'b0;
		tick(1);
		`CHK(run_out, 1'b1)
	endtask
	task resp_is(input [7:0] code);
		integer i;
		begin
			i = 0;
			do begin
				tick(1);
				i++;
			end while (resp_valid_ff !== 1'b1 && i < 12);
			bound(resp_valid_ff !== 1'b1);
			`CHK(resp_error_ff, code != 8'h00)
			`CHK(resp_code_ff, code)
			`CHK(resp_code_ff inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h11, 8'h12, 8'h15}, 1'b1)
		end
	endtask
	// f: 1 parity on the sum char, 2 corrupted sum
	task t_table;
		reg [39:0] b [0:9];
		integer    n [0:9], f [0:9];
		reg [7:0]  c [0:9];
		integer    k;
		begin
			b = '{40'h04, 40'h04, 40'h04, 40'h09, 40'h00_04, 40'h08_03, 40'h01_00_10_01,
				40'h02_ff_0f_01, 40'h10_01_00_00_02, 40'h02_fe_0f_01};
			n = '{1, 1, 1, 1, 2, 2, 4, 4, 5, 4};
			f = '{0, 1, 2, 0, 0, 0, 0, 0, 0, 0};
			c = '{8'h00, 8'h01, 8'h03, 8'h12, 8'h15, 8'h11, 8'h05, 8'h04, 8'h06, 8'h00};
			for (k = 0; k < 10; k++) begin
				pm.send(b[k], n[k], f[k] == 2, f[k] == 1 ? n[k] : -1);
				resp_is(c[k]);
				`CHK(exec_valid_ff, c[k] == 8'h00)
			end
			`CHK({exec_cmd_ff, exec_addr_ff, exec_count_ff}, 32'h01_0ffe_02)
			pm.send(64'h05_01_10_00_02, 5, 1'b0, -1);
			resp_is(8'h00);
			`CHK({exec_cmd_ff, exec_addr_ff, exec_count_ff, exec_node_ff}, 40'h02_0010_01_05)
		end
	endtask
	task t_overrun;
		fork
			pm.send(64'h01_00_00_01, 4, 1'b0, -1);
			begin
				repeat (2) @(posedge core_clk_in);
				proc_stall_in <= 1'b1;
				repeat (3) @(posedge core_clk_in);
				proc_stall_in <= 1'b0;
			end
		join
		resp_is(8'h02);
		`CHK(run_out, 1'b0)
	endtask
	task t_diag;
		integer i, k;
		begin
			diag_fault_in <= 12'hfff;
			tick(1);
			diag_fault_in <= 12'h000;
			tick(3);
			`CHK(diag_valid_out, 1'b0)
			`CHK(run_out, 1'b0)
			supervisory_in <= 1'b1;
			for (i = 0; i < 12; i++) begin
				for (k = 0; k < 8 && diag_valid_out !== 1'b1; k++) tick(1);
				bound(diag_valid_out !== 1'b1);
				`CHK(diag_code_out, 8'(96'h14_13_12_11_10_07_06_05_04_03_02_01 >> 8 * i))
				`CHK(diag_code_out[7:4] <= 4'h9 && diag_code_out[3:0] <= 4'h9, 1'b1)
				diag_ack_in <= 1'b1;
				tick(1);
				diag_ack_in <= 1'b0;
				tick(3);
			end
			`CHK(diag_valid_out, 1'b0)
		end
	endtask
	initial begin
		do_reset;
		t_table;
		t_overrun;
		do_reset;
		t_diag;
		complete_run;
	end
endmodule
`default_nettype wire
